// ===== dbi_ctrl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module dbi_ctrl_checker (
	// Watched ports
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [3:0] regAddr,
	input wire logic regWrStb,
	input wire logic regRdStb,
	input wire logic [15:0] regRdData,
	input wire logic startEvent,
	input wire logic drainedEvent
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	// Read answer only in its slot
	property p_rdIdle;
		!$past(regRdStb) |-> regRdData == 16'h0000;
	endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data out of slot");
	property p_drnPulse;
		drainedEvent |=> !drainedEvent;
	endproperty
	a_drnPulse: assert property (p_drnPulse) else $error("drain pulse too long");
	property p_drnCause;
		drainedEvent |-> $past(startEvent);
	endproperty
	a_drnCause: assert property (p_drnCause) else $error("drain without start");
	property p_stsBits;
		regRdStb && regAddr == 4'h7 |=> (regRdData & 16'hFF7F) == 16'h0000;
	endproperty
	a_stsBits: assert property (p_stsBits) else $error("status spare bits set");
	property p_flagBits;
		regRdStb && regAddr == 4'h6 |=> regRdData[15:3] == 13'h0000;
	endproperty
	a_flagBits: assert property (p_flagBits) else $error("flag spare bits set");
	// Data places are write-only, rest unmapped
	property p_woData;
		regRdStb && regAddr[3] |=> regRdData == 16'h0000;
	endproperty
	a_woData: assert property (p_woData) else $error("write-only read back");
	property p_busyHold;
		regWrStb && regAddr == 4'hC ##1 regRdStb && regAddr == 4'h7 |=> regRdData[7];
	endproperty
	a_busyHold: assert property (p_busyHold) else $error("busy missing");
	property p_unmap;
		regRdStb && regAddr == 4'h3 |=> regRdData == 16'h0000;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
endmodule // dbi_ctrl_checker
bind dbi_dac_ctrl dbi_ctrl_checker chk_u (.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
	.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .startEvent(startEvent),
	.drainedEvent(drainedEvent));
`default_nettype wire

// ===== dbi_dac_ctrl.v
`timescale 1ns/10ps
`default_nettype none
`include "dbi_regs.vh"
module dbi_dac_ctrl #(
	parameter SYNC_CYCLES = 4
) (
	// Clock and reset
	input wire ref_clk,
	input wire resetn,
	// Register port
	input wire [`DBI_ADDR_W-1:0] regAddr,
	input wire [15:0] regWrData,
	input wire regWrStb,
	input wire regRdStb,
	output reg [15:0] regRdData,
	// Event network
	input wire startEvent,
	output reg drainedEvent,
	// Converter core
	output reg [9:0] dacCode,
	// Interrupt
	output wire irqReq
);

	// Timing notes for users of this block:
	// a write to either data offset, or a transfer, opens a busy window
	// of SYNC_CYCLES clocks, and a new one restarts the window; the
	// converter code changes only when a window closes, so writes spaced
	// closer than the window hold the old code until they pause.
	// Reads have no side effects; flags only move on writes and events.
	// The hold buffer is a single word: software must refill it between
	// start events or an underrun is flagged and the code is kept.
	// A start event is taken on the edge where it is high, and its
	// effects show one clock later: the empty flag, the drained pulse
	// and the busy status together. Start events that find the input
	// disabled leave no trace at all, not even an underrun.
	// The request output is a level built from registered flags and
	// enables, so it never glitches on a register write.

	// Decode a write at one offset
	function wrHit;
		input [`DBI_ADDR_W-1:0] a;
		input [`DBI_ADDR_W-1:0] ofs;
		input stb;
		begin
			wrHit = stb && (a == ofs);
		end
	endfunction

	// Take ten sample bits out of a sixteen-bit word;
	// the six unused bits are ignored, never checked
	function [9:0] pickSample;
		input [15:0] w;
		input left;
		begin
			if (left) begin
				pickSample = w[15:6];
			end else begin
				pickSample = w[9:0];
			end
		end
	endfunction

	// Control bytes written by software
	reg [7:0] controlSecondary_q;
	reg [7:0] eventCtrl_q;

	// Interrupt state, one bit per source; the bits live in the
	// per-source slices below and are gathered into these vectors
	wire [2:0] irqEnable_q;
	wire [2:0] irqFlags_q;
	wire [2:0] irqFlags_d;
	wire [2:0] irqEnable_d;
	// Per-source requests, flag gated by its enable
	wire [2:0] irqSrcReq;

	// Sample path; one word waits, there is no deeper queue
	reg [15:0] holdBuf_q;
	reg holdFull_q;
	reg [15:0] convData_q;

	// Sync window; the counter only runs while busy,
	// and it is reloaded whenever a new window opens
	reg [3:0] syncCnt_q;
	reg syncPending_q;

	// Control fields
	wire msbJustify = controlSecondary_q[`DBI_CONTROL_SECONDARY_MSB_JUSTIFY];
	wire convertInEnable = eventCtrl_q[`DBI_EVCTRL_CONVERT_IN];
	wire drainedOutEnable = eventCtrl_q[`DBI_EVCTRL_DRAINED_OUT];

	// Write decodes; reads have no side effects
	wire wrHold = wrHit(regAddr, `DBI_OFS_SAMPLE_HOLD_BUFFER, regWrStb);
	wire wrData = wrHit(regAddr, `DBI_OFS_CONVERSION_DATA, regWrStb);
	wire wrFlags = wrHit(regAddr, `DBI_OFS_IRQ_FLAGS, regWrStb);
	wire wrSet = wrHit(regAddr, `DBI_OFS_IRQ_ENABLE_SET, regWrStb);
	wire wrClr = wrHit(regAddr, `DBI_OFS_IRQ_ENABLE_CLEAR, regWrStb);

	// start events count only when enabled
	wire startTaken = startEvent && convertInEnable;
	// Transfer only when a sample is waiting
	wire transfer = startTaken && holdFull_q;

	// Writes to either data offset, and transfers, open a sync window
	wire syncStart = wrHold || wrData;
	// Last busy cycle; the converter takes its code here
	wire syncDone = syncPending_q && (syncCnt_q == 4'h1);

	// Number of interrupt sources
	localparam NUM_IRQ = 3;

	// Hardware set events, one per interrupt source
	wire [2:0] flagSet;
	// Clear requests; written ones, plus new data for the empty flag
	wire [2:0] flagClr;
	// Enable requests from the set and clear offsets
	wire [2:0] enSet;
	wire [2:0] enClr;

	assign flagSet[`DBI_IRQ_UNDERRUN] = startTaken && !holdFull_q;
	assign flagSet[`DBI_IRQ_EMPTY] = transfer;
	// Sync done once the busy window closes
	assign flagSet[`DBI_IRQ_SYNC_DONE] = syncDone;

	// underrun cleared only by a written one
	assign flagClr[`DBI_IRQ_UNDERRUN] = wrFlags && regWrData[`DBI_IRQ_UNDERRUN];
	// empty cleared by a written one or new data
	assign flagClr[`DBI_IRQ_EMPTY] = (wrFlags && regWrData[`DBI_IRQ_EMPTY]) || wrHold;
	assign flagClr[`DBI_IRQ_SYNC_DONE] = wrFlags && regWrData[`DBI_IRQ_SYNC_DONE];

	assign enSet = wrSet ? regWrData[2:0] : 3'h0;
	// clear enables by ones; zeros leave enables alone
	// so no read-modify-write is needed to drop one source
	assign enClr = wrClr ? regWrData[2:0] : 3'h0;

	// One flag and one enable per source, identical slices;
	// a flag set in the same cycle as its clear stays set, so an
	// event is never lost to a late write of one
	genvar g;
	generate
		for (g = 0; g < NUM_IRQ; g = g + 1) begin : gIrq
			reg flag_q;
			reg enable_q;
			// Next flag; set beats clear
			assign irqFlags_d[g] = flagSet[g] || (flag_q && !flagClr[g]);
			// Next enable; clear beats set
			assign irqEnable_d[g] = (enable_q || enSet[g]) && !enClr[g];
			// Flag flop
			always @(posedge ref_clk) begin
				if (!resetn) begin
					flag_q <= 1'b0;
				end else begin
					flag_q <= irqFlags_d[g];
				end
			end
			// Enable flop, seen at both the set and clear offsets
			always @(posedge ref_clk) begin
				if (!resetn) begin
					enable_q <= 1'b0;
				end else begin
					enable_q <= irqEnable_d[g];
				end
			end
			// Vectors for read back and request
			assign irqFlags_q[g] = flag_q;
			assign irqEnable_q[g] = enable_q;
			assign irqSrcReq[g] = flag_q && enable_q;
		end
	endgenerate

	// combined request; a level that stays up
	// until software clears the flag or drops the enable
	assign irqReq = |irqSrcReq;

	// Decodes for the two plain control offsets
	wire wrCtrl = wrHit(regAddr, `DBI_OFS_CONTROL_SECONDARY, regWrStb);
	wire wrEvt = wrHit(regAddr, `DBI_OFS_EVENT_CTRL, regWrStb);

	// Second control byte; justification is only looked at
	// when a sync window closes, so a change takes effect then
	always @(posedge ref_clk) begin
		if (!resetn) begin
			controlSecondary_q <= `DBI_RESET_BYTE;
		end else if (wrCtrl) begin
			controlSecondary_q <= regWrData[7:0];
		end
	end

	// event control; bit 0 admits start events, bit 1 emits drains
	// Start events arriving while bit 0 is low are dropped, not queued
	always @(posedge ref_clk) begin
		if (!resetn) begin
			eventCtrl_q <= `DBI_RESET_BYTE;
		end else if (wrEvt) begin
			eventCtrl_q <= regWrData[7:0];
		end
	end

	// hold buffer keeps the next sample until copied
	// Write-only: nothing reads it back over the register port
	always @(posedge ref_clk) begin
		if (!resetn) begin
			holdBuf_q <= `DBI_RESET_WORD;
		end else if (wrHold) begin
			holdBuf_q <= regWrData;
		end
	end

	// Hold state; a write in the transfer cycle keeps it full,
	// since the new word arrives as the old one leaves
	always @(posedge ref_clk) begin
		if (!resetn) begin
			holdFull_q <= 1'b0;
		end else if (wrHold) begin
			holdFull_q <= 1'b1;
		end else if (transfer) begin
			holdFull_q <= 1'b0;
		end
	end

	// event copies hold into data; a direct write loads it too
	// but a transfer in the same cycle takes the buffered word
	always @(posedge ref_clk) begin
		if (!resetn) begin
			convData_q <= `DBI_RESET_WORD;
		end else if (transfer) begin
			convData_q <= holdBuf_q;
		end else if (wrData) begin
			convData_q <= regWrData;
		end
	end

	// drained event, one cycle per emptying transfer
	// No pulse is made for transfers while the output is disabled
	always @(posedge ref_clk) begin
		if (!resetn) begin
			drainedEvent <= 1'b0;
		end else begin
			drainedEvent <= transfer && drainedOutEnable;
		end
	end

	// Converter code, delayed by the sync window like the real crossing;
	// the justification in force when the window closes picks the slice
	always @(posedge ref_clk) begin
		if (!resetn) begin
			dacCode <= 10'h000;
		end else if (syncDone) begin
			dacCode <= pickSample(convData_q, msbJustify);
		end
	end

	// Sync window states
	localparam SYNC_IDLE = 1'b0;
	localparam SYNC_BUSY = 1'b1;

	// Write synchronisation busy; a new write restarts the window
	// so the crossing always carries the newest value, at the cost
	// of a longer wait under a steady write stream
	always @(posedge ref_clk) begin
		if (!resetn) begin
			syncPending_q <= SYNC_IDLE;
			syncCnt_q <= 4'h0;
		end else begin
			case (syncPending_q)
				SYNC_IDLE: begin
					if (syncStart || transfer) begin
						syncPending_q <= SYNC_BUSY;
						syncCnt_q <= SYNC_CYCLES[3:0];
					end
				end
				SYNC_BUSY: begin
					// Restart on a new write or transfer
					if (syncStart || transfer) begin
						syncCnt_q <= SYNC_CYCLES[3:0];
					end else begin
						syncCnt_q <= syncCnt_q - 4'h1;
						if (syncCnt_q == 4'h1) begin
							syncPending_q <= SYNC_IDLE;
						end
					end
				end
				// Unused code; fall back to idle
				default: begin
					syncPending_q <= SYNC_IDLE;
					syncCnt_q <= 4'h0;
				end
			endcase
		end
	end

	// Read word for the addressed offset
	// Write-only and unmapped offsets read as zero
	reg [15:0] rdWord;
	always @* begin
		rdWord = 16'h0000;
		case (regAddr)
			`DBI_OFS_CONTROL_SECONDARY: rdWord = {8'h00, controlSecondary_q};
			`DBI_OFS_EVENT_CTRL: rdWord = {8'h00, eventCtrl_q};
			`DBI_OFS_IRQ_ENABLE_CLEAR: rdWord = {13'h0, irqEnable_q};
			`DBI_OFS_IRQ_ENABLE_SET: rdWord = {13'h0, irqEnable_q};
			`DBI_OFS_IRQ_FLAGS: rdWord = {13'h0, irqFlags_q};
			`DBI_OFS_SYNC_STATUS: rdWord = {8'h00, syncPending_q, 7'h00};
			default: rdWord = 16'h0000;
		endcase
	end

	// Read data, one cycle after the strobe, zero otherwise
	// so a master that samples late sees nothing stale
	always @(posedge ref_clk) begin
		if (!resetn) begin
			regRdData <= `DBI_RESET_WORD;
		end else if (regRdStb) begin
			regRdData <= rdWord;
		end else begin
			regRdData <= 16'h0000;
		end
	end

endmodule // dbi_dac_ctrl
`default_nettype wire

// ===== dbi_evt_net.sv
`timescale 1ns/10ps
`default_nettype none
module dbi_evt_net (
	// Clock
	input wire logic ref_clk,
	// Event lines
	input wire logic fire,
	input wire logic drainedEvent,
	output logic startEvent,
	output var int drains
);
	initial startEvent = 1'h0;
	initial drains = 0;
	always @(posedge ref_clk) begin
		startEvent <= fire;
		drains <= drains + drainedEvent;
	end
endmodule // dbi_evt_net
`default_nettype wire

// ===== dbi_regs.vh
`ifndef DBI_REGS_VH
`define DBI_REGS_VH
// Register offsets (byte addresses on the plain port)
`define DBI_ADDR_W 4
`define DBI_OFS_CONTROL_SECONDARY 4'h1
`define DBI_OFS_EVENT_CTRL 4'h2
`define DBI_OFS_IRQ_ENABLE_CLEAR 4'h4
`define DBI_OFS_IRQ_ENABLE_SET 4'h5
`define DBI_OFS_IRQ_FLAGS 4'h6
`define DBI_OFS_SYNC_STATUS 4'h7
`define DBI_OFS_CONVERSION_DATA 4'h8
`define DBI_OFS_SAMPLE_HOLD_BUFFER 4'hC
// Interrupt bit positions
`define DBI_IRQ_UNDERRUN 0
`define DBI_IRQ_EMPTY 1
`define DBI_IRQ_SYNC_DONE 2
// Other field positions
`define DBI_CONTROL_SECONDARY_MSB_JUSTIFY 2
`define DBI_EVCTRL_CONVERT_IN 0
`define DBI_EVCTRL_DRAINED_OUT 1
`define DBI_STATUS_SYNC_PENDING 7
// Reset values
`define DBI_RESET_BYTE 8'h00
`define DBI_RESET_WORD 16'h0000
// Write synchronisation delay in ref_clk cycles
`define DBI_SYNC_CYCLES 4'h4
`endif

// ===== tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,e) begin num_checks++; if ((a)!==(e)) begin fail_count++; $display("[FAIL] %0t %h %h",$time,a,e); end end
module tb;
	logic ref_clk = 0, resetn = 0, regWrStb = 0, regRdStb = 0, rdPend = 0, fire = 0;
	logic [3:0] regAddr = 4'h0;
	logic [15:0] regWrData = 16'h0000, d, e;
	wire [15:0] regRdData;
	wire [9:0] dacCode;
	wire startEvent, drainedEvent, irqReq;
	int fail_count = 0, num_checks = 0, drains;
	logic [15:0] expQ[$];
	// 50 MHz clock
	always #10 ref_clk = ~ref_clk;
	dbi_dac_ctrl #(.SYNC_CYCLES(4)) dut_u (.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
		.startEvent(startEvent), .drainedEvent(drainedEvent), .dacCode(dacCode), .irqReq(irqReq));
	dbi_evt_net net_u (.ref_clk(ref_clk), .fire(fire), .drainedEvent(drainedEvent),
		.startEvent(startEvent), .drains(drains));
	// Bus cycle, held so calls run back to back
	task acc(input logic w, input logic [3:0] a, input logic [15:0] v);
		@(posedge ref_clk);
		if (!w) expQ.push_back(v);
		regAddr <= a;
		regWrData <= v;
		regWrStb <= w;
		regRdStb <= !w;
	endtask
	// Drop strobes, optionally pulse start
	task idle(input logic f);
		@(posedge ref_clk);
		regWrStb <= 1'h0;
		regRdStb <= 1'h0;
		fire <= f;
		@(posedge ref_clk);
		fire <= 1'h0;
		repeat (12) @(posedge ref_clk);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Oldest note against each read answer
	always @(posedge ref_clk) begin
		if (rdPend) begin
			e = expQ.pop_front();
			`CHK(regRdData, e)
		end
		rdPend <= regRdStb;
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		give_verdict;
	end
	initial begin
		void'($urandom(88209));
		repeat (4) @(posedge ref_clk);
		resetn <= 1'h1;
		for (int a = 1; a < 16; a++) acc(1'h0, a[3:0], 16'h0000);
		acc(1'h1, 4'h5, 16'h0003);
		acc(1'h0, 4'h5, 16'h0003);
		acc(1'h1, 4'h5, 16'h0000);
		acc(1'h1, 4'h4, 16'h0001);
		acc(1'h0, 4'h5, 16'h0002);
		acc(1'h0, 4'h4, 16'h0002);
		$display("enable test done");
		// Underrun with hold empty, masked first
		acc(1'h1, 4'h2, 16'h0003);
		idle(1'h1);
		acc(1'h0, 4'h6, 16'h0001);
		acc(1'h1, 4'h6, 16'h0000);
		acc(1'h0, 4'h6, 16'h0001);
		acc(1'h1, 4'h5, 16'h0001);
		idle(1'h0);
		`CHK(irqReq, 1'h1)
		acc(1'h1, 4'h6, 16'h0001);
		acc(1'h0, 4'h6, 16'h0000);
		$display("underrun test done");
		for (int j = 0; j < 2; j++) begin
			d = $urandom;
			acc(1'h1, 4'h1, {13'h0000, j[0], 2'h0});
			acc(1'h1, 4'hC, d);
			acc(1'h0, 4'h7, 16'h0080);
			idle(1'h0);
			acc(1'h0, 4'h7, 16'h0000);
			idle(1'h1);
			`CHK(dacCode, j ? d[15:6] : d[9:0])
			`CHK(drains, j + 1)
			acc(1'h0, 4'h6, 16'h0006);
			acc(1'h1, 4'h6, 16'h0004);
			acc(1'h1, 4'hC, d);
			acc(1'h0, 4'h6, 16'h0000);
			idle(1'h0);
		end
		$display("transfer test done");
		give_verdict;
	end
endmodule // tb
`default_nettype wire
